/* logic/adc_timing_pkg.sv */
package adc_timing_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFS_SCAN_START  = 8'h00;
  localparam logic [7:0]  OFS_CHANNEL_SEL = 8'h04;
  localparam logic [7:0]  OFS_SAMPLE_TIME = 8'h08;
  localparam logic [7:0]  OFS_TIMING_CFG  = 8'h0c;
  localparam logic [7:0]  OFS_RESULT      = 8'h14;
  localparam logic [7:0]  OFS_PIN_EN_LO   = 8'h1c;
  localparam logic [7:0]  OFS_PIN_EN_HI   = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CHANNEL_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_SAMPLE_TIME = 32'h0000_0000;
  localparam logic [31:0] RST_TIMING_CFG  = 32'h0000_0100;
  localparam logic [31:0] RST_PIN_EN      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          START_BIT       = 0;
  localparam int          CHAN_W          = 6;
  localparam int          SPT_W           = 8;
  localparam int          DIV_LSB         = 0;
  localparam int          DIV_W           = 3;
  localparam int          DELAY_LSB       = 4;
  localparam int          DELAY_W         = 2;
  localparam int          GAP_BIT         = 6;
  localparam int          WAIT_LSB        = 7;
  localparam int          WAIT_W          = 5;
  localparam int          CFG_W           = 12;
  localparam logic [11:0] CFG_USED_MASK   = 12'hff7;
  localparam int          RESULT_W        = 12;
  localparam int          PIN_HI_W        = 28;
  localparam logic [5:0]  LAST_EXT_CHAN   = 6'h3b;
  localparam logic [5:0]  INT_REF_CHAN    = 6'h3c;

  // ----------------------------------------------------------------
  // Timing, in converter clock periods
  // ----------------------------------------------------------------
  localparam int          CNT_W           = 11;
  localparam logic [10:0] SAMPLE_UNIT     = 11'h004;
  localparam logic [10:0] WAIT_BASE       = 11'h003;
  localparam logic [10:0] GAP_LEN         = 11'h001;
  localparam logic [10:0] DELAY_LEN_1     = 11'h002;
  localparam logic [10:0] DELAY_LEN_2     = 11'h004;
  localparam logic [10:0] DELAY_LEN_3     = 11'h008;

  // ----------------------------------------------------------------
  // Converter clock synthesis from mclk
  // ----------------------------------------------------------------
  localparam int          MCLK_MHZ        = 100;
  localparam int          ACC_W           = 8;
  localparam logic [7:0]  ACC_WRAP        = 8'(MCLK_MHZ * 2);
  localparam logic [7:0]  INC_8M          = 8'h10;
  localparam logic [7:0]  INC_6M          = 8'h0c;
  localparam logic [7:0]  INC_4M          = 8'h08;
  localparam logic [7:0]  INC_3M          = 8'h06;
  localparam logic [7:0]  INC_2M          = 8'h04;
  localparam logic [7:0]  INC_1M5         = 8'h03;
  localparam logic [7:0]  INC_1M          = 8'h02;
  localparam logic [7:0]  INC_0M5         = 8'h01;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DELAY,
    PH_SAMPLE,
    PH_GAP,
    PH_WAIT,
    PH_CONVERT
  } phase_t;

  typedef struct packed {
    logic        sample;
    logic        compare;
    logic        int_ref;
    logic [5:0]  chan;
    logic [11:0] dac_code;
  } analog_ctrl_t;

endpackage

/* logic/conv_clock_gen.sv */
module conv_clock_gen
  import adc_timing_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] div_sel,
  output logic                  tick_q
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             tick;
  } gen_state_t;

  gen_state_t s_q;
  gen_state_t s_d;

  function automatic logic [ACC_W-1:0] rate_inc(input logic [DIV_W-1:0] sel);
    unique case (sel)
      3'h0:    rate_inc = INC_8M;
      3'h1:    rate_inc = INC_6M;
      3'h2:    rate_inc = INC_4M;
      3'h3:    rate_inc = INC_3M;
      3'h4:    rate_inc = INC_2M;
      3'h5:    rate_inc = INC_1M5;
      3'h6:    rate_inc = INC_1M;
      default: rate_inc = INC_0M5;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Fractional accumulator: one tick per converter clock period.
  // ----------------------------------------------------------------
  always_comb begin
    logic [ACC_W:0] sum;
    sum = {1'b0, s_q.acc} + {1'b0, rate_inc(div_sel)};
    s_d = s_q;
    if (sum >= {1'b0, ACC_WRAP}) begin
      s_d.acc  = ACC_W'(sum - {1'b0, ACC_WRAP});
      s_d.tick = 1'b1;
    end else begin
      s_d.acc  = sum[ACC_W-1:0];
      s_d.tick = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;

endmodule // conv_clock_gen

/* logic/sar_engine.sv */
module sar_engine
  import adc_timing_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                tick,
  input  wire logic                go,
  input  wire logic                abort,
  input  wire logic                cmp_hi,
  output logic [RESULT_W-1:0]      code_q,
  output logic                     done_q
);

  typedef struct packed {
    logic                active;
    logic [3:0]          bitpos;
    logic [RESULT_W-1:0] code;
    logic                done;
  } sar_state_t;

  sar_state_t s_q;
  sar_state_t s_d;

  // ----------------------------------------------------------------
  // One trial bit per converter clock, most significant first.
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (abort) begin
      s_d.active = 1'b0;
    end else if (go) begin
      s_d.active = 1'b1;
      s_d.bitpos = 4'(RESULT_W - 1);
      s_d.code   = {1'b1, {(RESULT_W-1){1'b0}}};
    end else if (s_q.active && tick) begin
      s_d.code[s_q.bitpos] = cmp_hi;
      if (s_q.bitpos == 4'h0) begin
        s_d.active = 1'b0;
        s_d.done   = 1'b1;
      end else begin
        s_d.bitpos                 = s_q.bitpos - 4'h1;
        s_d.code[s_q.bitpos - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_q = s_q.code;
  assign done_q = s_q.done;

endmodule // sar_engine

/* logic/adc_channel_timing_control.sv */
// Overview of operation
// - A 6-bit channel field in bits 5:0 picks external inputs 0 to 59 by codes 0x00 to 0x3b.
// - Channel code 0x3c routes the internal reference source to the converter.
// - Sampling lasts (N+1)*4 converter clocks, N being the 8-bit sampling time field.
// - After sampling the block waits 3+W converter clocks; W codes 0 and 1 are not to be used.
// - Bit 6 adds a gap of zero or one converter clock between sampling and comparison.
// - Bits 5:4 delay sampling by 0, 2, 4 or 8 converter clocks.
// - Bits 2:0 set the converter clock to 8, 6, 4, 3, 2, 1.5, 1 or 0.5 MHz.
// - Writing the start bit from 0 to 1 starts one scan, and hardware clears it at the end.
// - A start is refused when the selected channel pin is not enabled for analog use.
//
// The implementer's own choice: strobed register access.
module adc_channel_timing_control
  import adc_timing_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              cmp_hi,
  output analog_ctrl_t           analog_ctrl,
  output logic                   scan_busy,
  output logic                   conv_tick
);

  typedef struct packed {
    logic                start;
    logic [CHAN_W-1:0]   chan;
    logic [SPT_W-1:0]    sample_length_field;
    logic [CFG_W-1:0]    cfg;
    logic [31:0]         pin_lo;
    logic [PIN_HI_W-1:0] pin_hi;
    logic [RESULT_W-1:0] result;
    logic [DATA_W-1:0]   rdata;
    phase_t              phase;
    logic [CNT_W-1:0]    cnt;
    logic                sar_go;
    analog_ctrl_t        ana;
  } ctl_state_t;

  ctl_state_t          s_q;
  ctl_state_t          s_d;
  logic                tick;
  logic [RESULT_W-1:0] sar_code;
  logic                sar_done;
  logic                abort;

  // ----------------------------------------------------------------
  // Helper decodes
  // ----------------------------------------------------------------
  function automatic logic chan_enabled(input logic [CHAN_W-1:0] ch,
                                        input logic [31:0] lo,
                                        input logic [PIN_HI_W-1:0] hi);
    if (ch == INT_REF_CHAN) begin
      chan_enabled = 1'b1;
    end else if (ch > LAST_EXT_CHAN) begin
      chan_enabled = 1'b0;
    end else if (ch < 6'h20) begin
      chan_enabled = lo[ch[4:0]];
    end else begin
      chan_enabled = hi[5'(ch - 6'h20)];
    end
  endfunction

  function automatic logic [CNT_W-1:0] delay_len(input logic [DELAY_W-1:0] code);
    unique case (code)
      2'h0:    delay_len = '0;
      2'h1:    delay_len = DELAY_LEN_1;
      2'h2:    delay_len = DELAY_LEN_2;
      default: delay_len = DELAY_LEN_3;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sample_len(input logic [SPT_W-1:0] n);
    sample_len = CNT_W'((CNT_W'(n) + CNT_W'(1)) * SAMPLE_UNIT);
  endfunction

  function automatic logic [CNT_W-1:0] wait_len(input logic [CFG_W-1:0] cfg);
    wait_len = WAIT_BASE + CNT_W'(cfg[WAIT_LSB +: WAIT_W]);
  endfunction

  // ----------------------------------------------------------------
  // Converter clock and approximation engine
  // ----------------------------------------------------------------
  conv_clock_gen u_clk (
    .mclk    (mclk),
    .rst     (rst),
    .div_sel (s_q.cfg[DIV_LSB +: DIV_W]),
    .tick_q  (tick)
  );

  sar_engine u_sar (
    .mclk   (mclk),
    .rst    (rst),
    .tick   (tick),
    .go     (s_q.sar_go),
    .abort  (abort),
    .cmp_hi (cmp_hi),
    .code_q (sar_code),
    .done_q (sar_done)
  );

  assign abort = wr && (addr == OFS_SCAN_START) && !wdata[START_BIT] && s_q.start;

  // ----------------------------------------------------------------
  // Register access and scan sequencing
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.rdata  = '0;
    s_d.sar_go = 1'b0;

    if (wr) begin
      unique case (addr)
        OFS_SCAN_START: begin
          if (wdata[START_BIT] && !s_q.start) begin
            if (chan_enabled(s_q.chan, s_q.pin_lo, s_q.pin_hi)) begin
              s_d.start = 1'b1;
              s_d.phase = PH_IDLE;
            end
          end else if (!wdata[START_BIT] && s_q.start) begin
            s_d.start = 1'b0;
          end
        end
        OFS_CHANNEL_SEL: begin
          if (!s_q.start) begin
            s_d.chan = wdata[CHAN_W-1:0];
          end
        end
        OFS_SAMPLE_TIME: begin
          if (!s_q.start) begin
            s_d.sample_length_field = wdata[SPT_W-1:0];
          end
        end
        OFS_TIMING_CFG: begin
          if (!s_q.start) begin
            s_d.cfg = wdata[CFG_W-1:0] & CFG_USED_MASK;
          end
        end
        OFS_PIN_EN_LO: s_d.pin_lo = wdata;
        OFS_PIN_EN_HI: s_d.pin_hi = wdata[PIN_HI_W-1:0];
        default: ;
      endcase
    end

    if (rd) begin
      unique case (addr)
        OFS_SCAN_START:  s_d.rdata = DATA_W'(s_q.start);
        OFS_CHANNEL_SEL: s_d.rdata = DATA_W'(s_q.chan);
        OFS_SAMPLE_TIME: s_d.rdata = DATA_W'(s_q.sample_length_field);
        OFS_TIMING_CFG:  s_d.rdata = DATA_W'(s_q.cfg);
        OFS_RESULT:      s_d.rdata = DATA_W'(s_q.result);
        OFS_PIN_EN_LO:   s_d.rdata = s_q.pin_lo;
        OFS_PIN_EN_HI:   s_d.rdata = DATA_W'(s_q.pin_hi);
        default:         s_d.rdata = '0;
      endcase
    end

    if (!s_q.start || abort) begin
      s_d.phase = PH_IDLE;
      s_d.cnt   = '0;
    end else if (tick) begin
      unique case (s_q.phase)
        PH_IDLE: begin
          if (delay_len(s_q.cfg[DELAY_LSB +: DELAY_W]) != '0) begin
            s_d.phase = PH_DELAY;
            s_d.cnt   = delay_len(s_q.cfg[DELAY_LSB +: DELAY_W]) - CNT_W'(1);
          end else begin
            s_d.phase = PH_SAMPLE;
            s_d.cnt   = sample_len(s_q.sample_length_field) - CNT_W'(1);
          end
        end
        PH_DELAY: begin
          if (s_q.cnt == '0) begin
            s_d.phase = PH_SAMPLE;
            s_d.cnt   = sample_len(s_q.sample_length_field) - CNT_W'(1);
          end else begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end
        end
        PH_SAMPLE: begin
          if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end else if (s_q.cfg[GAP_BIT]) begin
            s_d.phase = PH_GAP;
            s_d.cnt   = GAP_LEN - CNT_W'(1);
          end else begin
            s_d.phase = PH_WAIT;
            s_d.cnt   = wait_len(s_q.cfg) - CNT_W'(1);
          end
        end
        PH_GAP: begin
          s_d.phase = PH_WAIT;
          s_d.cnt   = wait_len(s_q.cfg) - CNT_W'(1);
        end
        PH_WAIT: begin
          if (s_q.cnt == '0) begin
            s_d.phase  = PH_CONVERT;
            s_d.sar_go = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end
        end
        PH_CONVERT: ;
      endcase
    end

    if (s_q.start && !abort && s_q.phase == PH_CONVERT && sar_done) begin
      s_d.result = sar_code;
      s_d.start  = 1'b0;
      s_d.phase  = PH_IDLE;
    end

    s_d.ana.sample   = (s_d.phase == PH_SAMPLE);
    s_d.ana.compare  = (s_d.phase == PH_CONVERT);
    s_d.ana.chan     = s_d.chan;
    s_d.ana.int_ref  = (s_d.chan == INT_REF_CHAN);
    s_d.ana.dac_code = sar_code;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.chan   <= RST_CHANNEL_SEL[CHAN_W-1:0];
      s_q.sample_length_field    <= RST_SAMPLE_TIME[SPT_W-1:0];
      s_q.cfg    <= RST_TIMING_CFG[CFG_W-1:0];
      s_q.pin_lo <= RST_PIN_EN;
      s_q.pin_hi <= RST_PIN_EN[PIN_HI_W-1:0];
      s_q.phase  <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata       = s_q.rdata;
  assign analog_ctrl = s_q.ana;
  assign scan_busy   = s_q.start;
  assign conv_tick   = tick;

endmodule // adc_channel_timing_control

/* verification/adc_timing_monitor.sv */
module adc_timing_monitor
  import adc_timing_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              cmp_hi,
  input wire analog_ctrl_t      analog_ctrl,
  input wire logic              scan_busy,
  input wire logic              conv_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Port checks.
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data not zero outside the read answer cycle");
  a_ref_routing: assert property (analog_ctrl.int_ref |-> analog_ctrl.chan == INT_REF_CHAN)
    else $error("internal reference routed for another channel code");
  a_chan_legal: assert property (analog_ctrl.sample |-> analog_ctrl.chan <= INT_REF_CHAN)
    else $error("sampling on an undefined channel code");
  a_phase_exclusive: assert property (!(analog_ctrl.sample && analog_ctrl.compare))
    else $error("sampling and comparing at once");
  a_tick_spacing: assert property (conv_tick |=> !conv_tick [*8])
    else $error("converter clock faster than the top rate");
  a_idle_quiet: assert property (!scan_busy |-> !(analog_ctrl.sample || analog_ctrl.compare))
    else $error("analog phase active while no scan runs");
  a_start_cause: assert property ($rose(scan_busy) |->
    $past(wr) && $past(addr) == OFS_SCAN_START && $past(wdata[START_BIT]))
    else $error("scan began without a start write");
  a_abort_stop: assert property (wr && addr == OFS_SCAN_START && !wdata[START_BIT] &&
    scan_busy |-> ##[1:3] !scan_busy)
    else $error("scan not stopped by clearing start");
  a_sample_tick: assert property ($rose(analog_ctrl.sample) |->
    conv_tick || $past(conv_tick) || $past(conv_tick, 2))
    else $error("sampling began off a converter clock");
  a_refuse_code: assert property (wr && addr == OFS_SCAN_START && wdata[START_BIT] &&
    !scan_busy && analog_ctrl.chan > INT_REF_CHAN |=> !scan_busy)
    else $error("scan started on an undefined channel code");
endmodule // adc_timing_monitor

bind adc_channel_timing_control adc_timing_monitor u_adc_timing_monitor (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cmp_hi(cmp_hi), .analog_ctrl(analog_ctrl), .scan_busy(scan_busy), .conv_tick(conv_tick)
);

/* verification/testbench.sv */
module testbench
  import adc_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and checks.
  // ----------------------------------------------------------------
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              cmp_hi = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  analog_ctrl_t      analog_ctrl;
  logic              scan_busy;
  logic              conv_tick;
  logic [11:0]       target = '0;
  logic [5:0]        seen_chan = '0;
  logic              seen_ref = 1'b0;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                ticks = 0;
  int                busy_ticks = 0;
  int                samp_ticks = 0;

  adc_channel_timing_control u_adc_channel_timing_control (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_hi(cmp_hi), .analog_ctrl(analog_ctrl), .scan_busy(scan_busy), .conv_tick(conv_tick)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (conv_tick === 1'b1) begin
      ticks++;
      if (scan_busy === 1'b1) busy_ticks++;
      if (analog_ctrl.sample === 1'b1) samp_ticks++;
    end
    if (analog_ctrl.sample === 1'b1) begin
      seen_chan = analog_ctrl.chan;
      seen_ref = analog_ctrl.int_ref;
    end
    cmp_hi <= (analog_ctrl.dac_code <= target);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge mclk);
    while (scan_busy !== 1'b0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    check(32'(scan_busy), 32'h0);
  endtask

  function automatic logic [31:0] near(input int a, input int b, input int tol);
    return 32'((a - b <= tol) && (b - a <= tol));
  endfunction

  function automatic int exp_scan(input int sample_length_field, input int del, input int gap, input int w);
    int dl[4] = '{0, 2, 4, 8};
    return 1 + dl[del] + (sample_length_field + 1) * 4 + gap + 3 + w + 12;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #500_000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [7:0]  ofs[3];
    logic [31:0] msk[3];
    int          inc[8];
    logic [31:0] v;
    logic [5:0]  ch;
    int          sample_length_field, del, gap, w, dv, t0;
    ofs = '{OFS_CHANNEL_SEL, OFS_SAMPLE_TIME, OFS_TIMING_CFG};
    msk = '{32'h0000_003f, 32'h0000_00ff, 32'h0000_0ff7};
    inc = '{16, 12, 8, 6, 4, 3, 2, 1};
    void'($urandom(8));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(OFS_CHANNEL_SEL, rv); check(rv, RST_CHANNEL_SEL);
    rd_reg(OFS_SAMPLE_TIME, rv); check(rv, RST_SAMPLE_TIME);
    rd_reg(OFS_TIMING_CFG, rv); check(rv, RST_TIMING_CFG);
    rd_reg(8'h40, rv); check(rv, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 4; k++) begin
        v = (k == 0) ? 32'hffff_ffff : $urandom;
        wr_reg(ofs[r], v);
        rd_reg(ofs[r], rv); check(rv, v & msk[r]);
      end
    end
    $display("test registers done");
    for (int d = 0; d < 8; d++) begin
      wr_reg(OFS_TIMING_CFG, 32'h100 | d);
      t0 = ticks;
      repeat (2000) @(posedge mclk);
      check(near(ticks - t0, inc[d] * 10, 2), 32'h1);
    end
    $display("test divider done");
    wr_reg(OFS_CHANNEL_SEL, 32'h5);
    wr_reg(OFS_SCAN_START, 32'h1);
    repeat (20) @(posedge mclk);
    check(32'(scan_busy), 32'h0);
    wr_reg(OFS_PIN_EN_LO, 32'hffff_ffff);
    wr_reg(OFS_PIN_EN_HI, 32'h0fff_ffff);
    wr_reg(OFS_CHANNEL_SEL, 32'h3d);
    wr_reg(OFS_SCAN_START, 32'h1);
    repeat (20) @(posedge mclk);
    check(32'(scan_busy), 32'h0);
    $display("test refusal done");
    for (int i = 0; i < 4; i++) begin
      ch = (i == 3) ? INT_REF_CHAN : 6'($urandom % 60);
      sample_length_field = $urandom % 8;
      del = i;
      gap = (i == 1 || i == 2) ? 1 : 0;
      w = (i == 0) ? 2 : (i == 1) ? 31 : 2 + $urandom % 30;
      dv = (i == 3) ? 3 : 0;
      target = 12'($urandom);
      wr_reg(OFS_CHANNEL_SEL, {26'h0, ch});
      wr_reg(OFS_SAMPLE_TIME, 32'(sample_length_field));
      wr_reg(OFS_TIMING_CFG, {20'h0, w[4:0], gap[0], del[1:0], 1'b0, dv[2:0]});
      busy_ticks = 0;
      samp_ticks = 0;
      wr_reg(OFS_SCAN_START, 32'h1);
      wait_idle();
      check(near(busy_ticks, exp_scan(sample_length_field, del, gap, w), 1), 32'h1);
      check(near(samp_ticks, (sample_length_field + 1) * 4, 1), 32'h1);
      check(32'(seen_chan), 32'(ch));
      check(32'(seen_ref), 32'(ch == INT_REF_CHAN));
      rd_reg(OFS_RESULT, rv); check(rv, {20'h0, target});
      rd_reg(OFS_SCAN_START, rv); check(rv, 32'h0);
    end
    $display("test scans done");
    wr_reg(OFS_CHANNEL_SEL, 32'h1);
    wr_reg(OFS_SAMPLE_TIME, 32'hff);
    wr_reg(OFS_SCAN_START, 32'h1);
    repeat (50) @(posedge mclk);
    check(32'(scan_busy), 32'h1);
    wr_reg(OFS_SCAN_START, 32'h0);
    repeat (3) @(posedge mclk);
    check(32'(scan_busy), 32'h0);
    $display("test abort done");
    summarize();
  end
endmodule // testbench
